// File: hdl/cbf_pkg.sv
package cbf_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] CBF_ADDR_MASK_GATE = 3'h0;
    localparam logic [2:0] CBF_ADDR_FILTER = 3'h1;
    localparam logic [2:0] CBF_ADDR_VREF_ONE = 3'h2;
    localparam logic [2:0] CBF_ADDR_VREF_TWO = 3'h3;
    localparam logic [2:0] CBF_ADDR_MASK_SRC = 3'h4;
    localparam logic [2:0] CBF_ADDR_STATUS = 3'h5;
    // Reset values
    localparam logic [15:0] CBF_RST_MASK_GATE = 16'h0000;
    localparam logic [15:0] CBF_RST_FILTER = 16'h0000;
    localparam logic [15:0] CBF_RST_VREF = 16'h0000;
    localparam logic [15:0] CBF_RST_MASK_SRC = 16'h0000;
    // Writable bits of each register
    localparam logic [15:0] CBF_WMASK_MASK_GATE = 16'hbfff;
    localparam logic [15:0] CBF_WMASK_FILTER = 16'h007f;
    localparam logic [15:0] CBF_WMASK_VREF = 16'hcc7f;
    localparam logic [15:0] CBF_WMASK_MASK_SRC = 16'h0fff;
    // Mask gating field positions
    localparam int CBF_MG_LEVEL = 15;
    localparam int CBF_MG_OR_C = 13;
    localparam int CBF_MG_OR_CN = 12;
    localparam int CBF_MG_OR_B = 11;
    localparam int CBF_MG_OR_BN = 10;
    localparam int CBF_MG_OR_A = 9;
    localparam int CBF_MG_OR_AN = 8;
    localparam int CBF_MG_AND_INV = 7;
    localparam int CBF_MG_AND_TRUE = 6;
    localparam int CBF_MG_AND_C = 5;
    localparam int CBF_MG_AND_CN = 4;
    localparam int CBF_MG_AND_B = 3;
    localparam int CBF_MG_AND_BN = 2;
    localparam int CBF_MG_AND_A = 1;
    localparam int CBF_MG_AND_AN = 0;
    // Filter control field positions
    localparam int CBF_FL_SEL_LSB = 4;
    localparam int CBF_FL_EN = 3;
    localparam int CBF_FL_DIV_LSB = 0;
    // Reference control field positions
    localparam int CBF_VR_EN = 15;
    localparam int CBF_VR_OE = 14;
    localparam int CBF_VR_SS = 11;
    localparam int CBF_VR_SEL = 10;
    localparam int CBF_VR_LVL_LSB = 0;
    // Mask source field positions
    localparam int CBF_MS_A_LSB = 0;
    localparam int CBF_MS_B_LSB = 4;
    localparam int CBF_MS_C_LSB = 8;
    // Filter clock select codes
    localparam logic [2:0] CBF_FSEL_PERIPH = 3'h0;
    localparam logic [2:0] CBF_FSEL_OSC = 3'h1;
    localparam logic [2:0] CBF_FSEL_SYNC = 3'h2;
    localparam logic [2:0] CBF_FSEL_RSVD = 3'h3;
    localparam logic [2:0] CBF_FSEL_TMR2 = 3'h4;
    localparam logic [2:0] CBF_FSEL_TMR3 = 3'h5;
    localparam logic [2:0] CBF_FSEL_TMR4 = 3'h6;
    localparam logic [2:0] CBF_FSEL_TMR5 = 3'h7;
    // Mask source codes
    localparam logic [3:0] CBF_SRC_PWM_LAST = 4'h5;
    localparam logic [3:0] CBF_SRC_FAULT_A = 4'he;
    localparam logic [3:0] CBF_SRC_FAULT_B = 4'hf;
    // Consecutive agreeing samples before the filter output moves
    localparam logic [1:0] CBF_FILT_AGREE = 2'h3;
endpackage

// File: hdl/cbf_ctrl.sv
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module cbf_ctrl
    import cbf_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [15:0] RDATA_O,
    input wire logic CMP_I,
    input wire logic [5:0] PWM_I,
    input wire logic [1:0] FAULT_I,
    input wire logic PERIPH_CLK_I,
    input wire logic OSC_CLK_I,
    input wire logic SYNC_I,
    input wire logic [3:0] TIMER_CLK_I,
    output logic CMP_O,
    output logic BLANK_O,
    output logic VREF1_EN_O,
    output logic VREF1_PIN_OE_O,
    output logic VREF1_EXT_SRC_O,
    output logic VREF1_EXT_IN_O,
    output logic [6:0] VREF1_LEVEL_O,
    output logic VREF2_EN_O,
    output logic VREF2_PIN_OE_O,
    output logic VREF2_EXT_SRC_O,
    output logic VREF2_EXT_IN_O,
    output logic [6:0] VREF2_LEVEL_O
);

    typedef struct packed {
        logic [15:0] mask_gate;
        logic [15:0] filter;
        logic [15:0] vref_one;
        logic [15:0] vref_two;
        logic [15:0] mask_src;
        logic [15:0] rdata;
        logic [1:0] cmp_sync;
        logic [7:0] pin_sync_a;
        logic [7:0] pin_sync_b;
        logic [9:0] clk_sync_a;
        logic [9:0] clk_sync_b;
        logic src_clk_prev;
        logic [6:0] div_cnt;
        logic [1:0] agree_cnt;
        logic filt_out;
        logic cmp_out;
        logic blank;
    } cbf_state_s;

    cbf_state_s cur_ff;
    cbf_state_s nxt_ff;

    // Picks one mask source; reserved codes give a quiet low mask
    function automatic logic cbf_mask_pick(input logic [3:0] code, input logic [5:0] pwm, input logic [1:0] flt);
        logic res;
        res = 1'b0;
        if (code <= CBF_SRC_PWM_LAST)
        begin
            res = pwm[code[2:0]];
        end
        else if (code == CBF_SRC_FAULT_A)
        begin
            res = flt[0];
        end
        else if (code == CBF_SRC_FAULT_B)
        begin
            res = flt[1];
        end
        return res;
    endfunction

    logic [9:0] raw_in;
    logic mask_a;
    logic mask_b;
    logic mask_c;
    logic and_term;
    logic or_term;
    logic sel_clk;
    logic tick;
    logic blanked;
    logic [7:0] div_terminal;

    // Raw clock source pins, packed to match the select decode; they are synchronised before use
    assign raw_in = {TIMER_CLK_I, SYNC_I, OSC_CLK_I, PERIPH_CLK_I, 3'h0};

    always_comb
    begin
        nxt_ff = cur_ff;
        // PWM and fault pins pass two flops first; picking from raw pins could mix two sample times
        nxt_ff.pin_sync_a = {FAULT_I, PWM_I};
        nxt_ff.pin_sync_b = cur_ff.pin_sync_a;
        // Mask source selection, per input, from the source register
        mask_a = cbf_mask_pick(cur_ff.mask_src[CBF_MS_A_LSB +: 4],
            cur_ff.pin_sync_b[5:0], cur_ff.pin_sync_b[7:6]);
        mask_b = cbf_mask_pick(cur_ff.mask_src[CBF_MS_B_LSB +: 4],
            cur_ff.pin_sync_b[5:0], cur_ff.pin_sync_b[7:6]);
        mask_c = cbf_mask_pick(cur_ff.mask_src[CBF_MS_C_LSB +: 4],
            cur_ff.pin_sync_b[5:0], cur_ff.pin_sync_b[7:6]);
        nxt_ff.cmp_sync = {cur_ff.cmp_sync[0], CMP_I};
        nxt_ff.clk_sync_a = raw_in;
        nxt_ff.clk_sync_b = cur_ff.clk_sync_a;

        // AND gate: an enabled term that is low pulls it low; no term gives low
        and_term = (cur_ff.mask_gate[CBF_MG_AND_A] | cur_ff.mask_gate[CBF_MG_AND_AN] |
                    cur_ff.mask_gate[CBF_MG_AND_B] | cur_ff.mask_gate[CBF_MG_AND_BN] |
                    cur_ff.mask_gate[CBF_MG_AND_C] | cur_ff.mask_gate[CBF_MG_AND_CN])
            & (~cur_ff.mask_gate[CBF_MG_AND_A] | mask_a)
            & (~cur_ff.mask_gate[CBF_MG_AND_AN] | ~mask_a)
            & (~cur_ff.mask_gate[CBF_MG_AND_B] | mask_b)
            & (~cur_ff.mask_gate[CBF_MG_AND_BN] | ~mask_b)
            & (~cur_ff.mask_gate[CBF_MG_AND_C] | mask_c)
            & (~cur_ff.mask_gate[CBF_MG_AND_CN] | ~mask_c);

        // OR gate collects direct mask terms and the AND output
        or_term = (cur_ff.mask_gate[CBF_MG_OR_C] & mask_c)
            | (cur_ff.mask_gate[CBF_MG_OR_CN] & ~mask_c)
            | (cur_ff.mask_gate[CBF_MG_OR_B] & mask_b)
            | (cur_ff.mask_gate[CBF_MG_OR_BN] & ~mask_b)
            | (cur_ff.mask_gate[CBF_MG_OR_A] & mask_a)
            | (cur_ff.mask_gate[CBF_MG_OR_AN] & ~mask_a)
            | (cur_ff.mask_gate[CBF_MG_AND_TRUE] & and_term)
            | (cur_ff.mask_gate[CBF_MG_AND_INV] & ~and_term);

        // Blanking forces the non-asserted level: level select 1 means asserted is 0
        if (or_term)
        begin
            blanked = cur_ff.mask_gate[CBF_MG_LEVEL];
        end
        else
        begin
            blanked = cur_ff.cmp_sync[1];
        end
        nxt_ff.blank = or_term;

        // Filter clock pick; reserved code yields no ticks at all
        unique case (cur_ff.filter[CBF_FL_SEL_LSB +: 3])
            CBF_FSEL_PERIPH: sel_clk = cur_ff.clk_sync_b[3];
            CBF_FSEL_OSC: sel_clk = cur_ff.clk_sync_b[4];
            CBF_FSEL_SYNC: sel_clk = cur_ff.clk_sync_b[5];
            CBF_FSEL_RSVD: sel_clk = 1'b0;
            CBF_FSEL_TMR2: sel_clk = cur_ff.clk_sync_b[6];
            CBF_FSEL_TMR3: sel_clk = cur_ff.clk_sync_b[7];
            CBF_FSEL_TMR4: sel_clk = cur_ff.clk_sync_b[8];
            CBF_FSEL_TMR5: sel_clk = cur_ff.clk_sync_b[9];
        endcase
        nxt_ff.src_clk_prev = sel_clk;

        // Power-of-two divider on rising edges of the picked clock
        div_terminal = 8'h01 << cur_ff.filter[CBF_FL_DIV_LSB +: 3];
        tick = 1'b0;
        if (sel_clk & ~cur_ff.src_clk_prev)
        begin
            if ({1'b0, cur_ff.div_cnt} + 8'h01 >= div_terminal)
            begin
                nxt_ff.div_cnt = 7'h00;
                tick = 1'b1;
            end
            else
            begin
                nxt_ff.div_cnt = cur_ff.div_cnt + 7'h01;
            end
        end

        // Majority-free agreement filter; a disagreeing sample restarts the count
        if (tick)
        begin
            if (blanked == cur_ff.filt_out)
            begin
                nxt_ff.agree_cnt = 2'h0;
            end
            else if (cur_ff.agree_cnt + 2'h1 >= CBF_FILT_AGREE)
            begin
                nxt_ff.agree_cnt = 2'h0;
                nxt_ff.filt_out = blanked;
            end
            else
            begin
                nxt_ff.agree_cnt = cur_ff.agree_cnt + 2'h1;
            end
        end
        if (!cur_ff.filter[CBF_FL_EN])
        begin
            // Bypass keeps the filter tracking so enabling causes no glitch
            nxt_ff.filt_out = blanked;
            nxt_ff.agree_cnt = 2'h0;
            nxt_ff.cmp_out = blanked;
        end
        else
        begin
            nxt_ff.cmp_out = cur_ff.filt_out;
        end

        // Register writes; unimplemented bits are masked off
        if (WR_I)
        begin
            unique case (ADDR_I)
                CBF_ADDR_MASK_GATE: nxt_ff.mask_gate = WDATA_I & CBF_WMASK_MASK_GATE;
                CBF_ADDR_FILTER:
                begin
                    nxt_ff.filter = WDATA_I & CBF_WMASK_FILTER;
                    // A new source or ratio restarts divider and count, so the first period is whole;
                    // the edge memory is set high so switching sources never fakes a rising edge
                    nxt_ff.src_clk_prev = 1'b1;
                    nxt_ff.div_cnt = 7'h00;
                    nxt_ff.agree_cnt = 2'h0;
                end
                CBF_ADDR_VREF_ONE: nxt_ff.vref_one = WDATA_I & CBF_WMASK_VREF;
                CBF_ADDR_VREF_TWO: nxt_ff.vref_two = WDATA_I & CBF_WMASK_VREF;
                CBF_ADDR_MASK_SRC: nxt_ff.mask_src = WDATA_I & CBF_WMASK_MASK_SRC;
                default: nxt_ff.mask_src = cur_ff.mask_src;
            endcase
        end

        // Read data stand only in the cycle after the strobe
        nxt_ff.rdata = 16'h0000;
        if (RD_I)
        begin
            unique case (ADDR_I)
                CBF_ADDR_MASK_GATE: nxt_ff.rdata = cur_ff.mask_gate;
                CBF_ADDR_FILTER: nxt_ff.rdata = cur_ff.filter;
                CBF_ADDR_VREF_ONE: nxt_ff.rdata = cur_ff.vref_one;
                CBF_ADDR_VREF_TWO: nxt_ff.rdata = cur_ff.vref_two;
                CBF_ADDR_MASK_SRC: nxt_ff.rdata = cur_ff.mask_src;
                CBF_ADDR_STATUS: nxt_ff.rdata = {13'h0000, cur_ff.blank, cur_ff.filt_out, cur_ff.cmp_out};
                default: nxt_ff.rdata = 16'h0000;
            endcase
        end
    end

    // Single state register, synchronous active-low reset
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_B_I)
        begin
            cur_ff <= '0;
            cur_ff.mask_gate <= CBF_RST_MASK_GATE;
            cur_ff.filter <= CBF_RST_FILTER;
            cur_ff.vref_one <= CBF_RST_VREF;
            cur_ff.vref_two <= CBF_RST_VREF;
            cur_ff.mask_src <= CBF_RST_MASK_SRC;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    // Outputs straight from state
    assign RDATA_O = cur_ff.rdata;
    assign CMP_O = cur_ff.cmp_out;
    assign BLANK_O = cur_ff.blank;
    assign VREF1_EN_O = cur_ff.vref_one[CBF_VR_EN];
    assign VREF1_PIN_OE_O = cur_ff.vref_one[CBF_VR_OE];
    assign VREF1_EXT_SRC_O = cur_ff.vref_one[CBF_VR_SS];
    assign VREF1_EXT_IN_O = cur_ff.vref_one[CBF_VR_SEL];
    assign VREF1_LEVEL_O = cur_ff.vref_one[CBF_VR_LVL_LSB +: 7];
    assign VREF2_EN_O = cur_ff.vref_two[CBF_VR_EN];
    assign VREF2_PIN_OE_O = cur_ff.vref_two[CBF_VR_OE];
    assign VREF2_EXT_SRC_O = cur_ff.vref_two[CBF_VR_SS];
    assign VREF2_EXT_IN_O = cur_ff.vref_two[CBF_VR_SEL];
    assign VREF2_LEVEL_O = cur_ff.vref_two[CBF_VR_LVL_LSB +: 7];

endmodule

// File: sim/cbf_ctrl_properties.sv
`timescale 1ns/1ps
module cbf_ctrl_properties
(
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [15:0] RDATA_O,
    input wire logic VREF1_EN_O,
    input wire logic VREF1_PIN_OE_O,
    input wire logic VREF1_EXT_SRC_O,
    input wire logic VREF1_EXT_IN_O,
    input wire logic [6:0] VREF1_LEVEL_O,
    input wire logic VREF2_EN_O,
    input wire logic VREF2_PIN_OE_O,
    input wire logic VREF2_EXT_SRC_O,
    input wire logic VREF2_EXT_IN_O,
    input wire logic [6:0] VREF2_LEVEL_O
);
    logic [15:0] wdata_ff;
    // Write data kept one cycle so the effect of a write can be compared
    always_ff @(posedge CLOCK_I)
    begin
        wdata_ff <= WDATA_I;
    end
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    // A read strobe at a given register index
    sequence s_rd_at(logic [2:0] a);
        RD_I && ADDR_I == a;
    endsequence
    sequence s_wr_at(logic [2:0] a);
        WR_I && ADDR_I == a;
    endsequence
    a_rdata_idle: assert property (!RD_I |=> RDATA_O == 16'h0000) else $error("read data not zero when idle");
    a_filter_unimpl: assert property (s_rd_at(3'h1) |=> RDATA_O[15:7] == 9'h000) else $error("filter high bits");
    a_gate_bit14: assert property (s_rd_at(3'h0) |=> !RDATA_O[14]) else $error("gating bit 14 not zero");
    a_unmapped_zero: assert property (RD_I && ADDR_I > 3'h5 |=> RDATA_O == 16'h0000) else $error("unmapped read");
    a_vref1_view: assert property (s_rd_at(3'h2) |=> RDATA_O == {VREF1_EN_O, VREF1_PIN_OE_O, 2'b00,
        VREF1_EXT_SRC_O, VREF1_EXT_IN_O, 3'b000, VREF1_LEVEL_O}) else $error("first reference read");
    a_vref2_view: assert property (s_rd_at(3'h3) |=> RDATA_O == {VREF2_EN_O, VREF2_PIN_OE_O, 2'b00,
        VREF2_EXT_SRC_O, VREF2_EXT_IN_O, 3'b000, VREF2_LEVEL_O}) else $error("second reference read");
    a_vref1_write: assert property (s_wr_at(3'h2) |=> VREF1_LEVEL_O == wdata_ff[6:0] && VREF1_EN_O == wdata_ff[15])
        else $error("first reference write");
    a_vref2_write: assert property (s_wr_at(3'h3) |=> VREF2_PIN_OE_O == wdata_ff[14]
        && VREF2_EXT_SRC_O == wdata_ff[11] && VREF2_EXT_IN_O == wdata_ff[10]) else $error("second reference write");
    a_vref1_hold: assert property (!(WR_I && ADDR_I == 3'h2) |=> $stable(VREF1_LEVEL_O)) else $error("level moved");
endmodule
bind cbf_ctrl cbf_ctrl_properties u_props (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .VREF1_EN_O(VREF1_EN_O), .VREF1_PIN_OE_O(VREF1_PIN_OE_O),
    .VREF1_EXT_SRC_O(VREF1_EXT_SRC_O), .VREF1_EXT_IN_O(VREF1_EXT_IN_O), .VREF1_LEVEL_O(VREF1_LEVEL_O),
    .VREF2_EN_O(VREF2_EN_O), .VREF2_PIN_OE_O(VREF2_PIN_OE_O), .VREF2_EXT_SRC_O(VREF2_EXT_SRC_O),
    .VREF2_EXT_IN_O(VREF2_EXT_IN_O), .VREF2_LEVEL_O(VREF2_LEVEL_O));

// File: sim/cbf_ctrl_test.sv
`timescale 1ns/1ps
module cbf_ctrl_test;
    logic CLOCK_I = 0, RST_B_I = 0, WR_I = 0, RD_I = 0, CMP_I = 0, SYNC_I = 0, OSC_CLK_I = 0, PERIPH_CLK_I = 0;
    logic [2:0] ADDR_I = 3'h0;
    logic [15:0] WDATA_I = 16'h0000;
    logic [5:0] PWM_I = 6'h00;
    logic [1:0] FAULT_I = 2'h0;
    logic [3:0] TIMER_CLK_I = 4'h0;
    logic [6:0] src_on = 7'h00;
    logic [1:0] cnt = 2'h0;
    logic [15:0] RDATA_O;
    wire [10:0] vr1, vr2;
    logic CMP_O, BLANK_O, cur;
    int errors = 0, tests_run = 0;
    cbf_ctrl DUT (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
        .RDATA_O(RDATA_O), .CMP_I(CMP_I), .PWM_I(PWM_I), .FAULT_I(FAULT_I), .PERIPH_CLK_I(PERIPH_CLK_I),
        .OSC_CLK_I(OSC_CLK_I), .SYNC_I(SYNC_I), .TIMER_CLK_I(TIMER_CLK_I), .CMP_O(CMP_O), .BLANK_O(BLANK_O),
        .VREF1_EN_O(vr1[10]), .VREF1_PIN_OE_O(vr1[9]), .VREF1_EXT_SRC_O(vr1[8]), .VREF1_EXT_IN_O(vr1[7]),
        .VREF1_LEVEL_O(vr1[6:0]), .VREF2_EN_O(vr2[10]), .VREF2_PIN_OE_O(vr2[9]), .VREF2_EXT_SRC_O(vr2[8]),
        .VREF2_EXT_IN_O(vr2[7]), .VREF2_LEVEL_O(vr2[6:0]));
    always #25 CLOCK_I = ~CLOCK_I;
    // Filter clock sources run at a quarter of the system clock; only enabled ones toggle
    always @(posedge CLOCK_I)
    begin
        cnt <= cnt + 2'h1;
        {TIMER_CLK_I, SYNC_I, OSC_CLK_I, PERIPH_CLK_I} <= {7{cnt[1]}} & src_on;
    end
    // Tasks resume 1 ns after an edge so outputs of that edge have landed
    task cyc(input int n);
        repeat (n) @(posedge CLOCK_I);
        #1;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [2:0] a, input logic [15:0] d);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        cyc(1);
        WR_I <= 1'b0;
        cyc(1);
    endtask
    task rd(input logic [2:0] a, input logic [15:0] exp);
        ADDR_I <= a;
        RD_I <= 1'b1;
        cyc(1);
        RD_I <= 1'b0;
        chk(RDATA_O, exp);
        cyc(1);
    endtask
    // Blanking expected from the gate settings; an AND gate with no input reads 0
    function automatic logic blank_of(input logic [15:0] g, input logic a, input logic b, input logic c);
        logic [5:0] t;
        logic ando;
        t = {c, ~c, b, ~b, a, ~a};
        ando = (g[5:0] != 6'h00) && ((t | ~g[5:0]) == 6'h3f);
        return (|(t & g[13:8])) | (g[6] & ando) | (g[7] & ~ando);
    endfunction
    task t_regs;
        logic [15:0] m [5];
        m = '{16'hbfff, 16'h007f, 16'hcc7f, 16'hcc7f, 16'h0fff};
        for (int a = 0; a < 8; a++) rd(a[2:0], 16'h0000);
        for (int a = 0; a < 5; a++)
        begin
            wr(a[2:0], 16'hffff);
            rd(a[2:0], m[a]);
        end
        wr(3'h7, 16'hffff);
        rd(3'h7, 16'h0000);
        wr(3'h2, 16'h8805);
        wr(3'h3, 16'h4435);
        chk(vr1, {5'h00, 4'ha, 7'h05});
        chk(vr2, {5'h00, 4'h5, 7'h35});
        wr(3'h0, 16'h0000);
        wr(3'h1, 16'h0000);
        $display("registers done");
    endtask
    task t_gate;
        logic [15:0] g;
        wr(3'h4, 16'h05e0);
        for (int i = 0; i < 16; i++)
        begin
            g = (i == 14) ? 16'h004a : (i == 15) ? 16'h80a1 : 16'h0001 << i;
            wr(3'h0, g);
            for (int j = 0; j < 8; j++)
            begin
                PWM_I <= {j[2], 4'h0, j[0]};
                FAULT_I <= {1'b0, j[1]};
                cyc(6);
                chk(BLANK_O, blank_of(g, j[0], j[1], j[2]));
            end
        end
        $display("gating done");
    endtask
    task t_src;
        wr(3'h0, 16'h0200);
        for (int c = 0; c < 16; c++)
        begin
            wr(3'h4, {12'h000, c[3:0]});
            for (int k = 0; k < 8; k++)
            begin
                {FAULT_I, PWM_I} <= 8'h01 << k;
                cyc(6);
                chk(BLANK_O, (c < 6 && k == c) || (c == 14 && k == 6) || (c == 15 && k == 7));
            end
        end
        $display("sources done");
    endtask
    task t_level;
        wr(3'h4, 16'h0000);
        for (int k = 0; k < 8; k++)
        begin
            wr(3'h0, {k[2], 15'h0200});
            PWM_I <= {5'h00, k[1]};
            CMP_I <= k[0];
            cyc(6);
            chk(CMP_O, k[1] ? k[2] : k[0]);
            rd(3'h5, {13'h0000, k[1], {2{k[1] ? k[2] : k[0]}}});
        end
        $display("level done");
    endtask
    task t_filter;
        int n;
        wr(3'h0, 16'h0000);
        CMP_I <= 1'b0;
        cur = 1'b0;
        cyc(6);
        // Other sources toggle while the selected one stands, then only the selected one runs; under the reserved code all seven toggle in both phases
        for (int s = 0; s < 8; s++)
        begin
            src_on <= (s == 3) ? 7'h7f : 7'h7f ^ (7'h01 << (s - (s > 3)));
            wr(3'h1, {9'h000, s[2:0], 4'h8});
            CMP_I <= ~cur;
            cyc(40);
            chk(CMP_O, cur);
            src_on <= (s == 3) ? 7'h7f : 7'h01 << (s - (s > 3));
            cyc(40);
            if (s != 3) cur = ~cur;
            chk(CMP_O, cur);
        end
        src_on <= 7'h01;
        for (int d = 0; d < 8; d++)
        begin
            wr(3'h1, {13'h0001, d[2:0]});
            CMP_I <= ~cur;
            n = 0;
            while (CMP_O === cur && n < 2000)
            begin
                cyc(1);
                n++;
            end
            if (n == 2000)
            begin
                errors++;
                end_sim;
            end
            cur = ~cur;
            chk(n >= (8 << d) && n <= (12 << d) + 10, 1'b1);
        end
        // A pulse shorter than two tick periods must not pass
        wr(3'h1, 16'h0008);
        CMP_I <= ~cur;
        cyc(5);
        CMP_I <= cur;
        cyc(30);
        chk(CMP_O, cur);
        $display("filter done");
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        cyc(2);
        RST_B_I <= 1'b1;
        t_regs;
        t_gate;
        t_src;
        t_level;
        t_filter;
        end_sim;
    end
endmodule
